// *** srx_pkg.sv ***
// Package of constants and carrier types for the static RAM expansion controller
package srx_pkg;
   // ****************************************************************
   // Array geometry
   // ****************************************************************
   localparam int SRX_ADDR_W = 16;             // Host byte address width
   localparam int SRX_DATA_W = 16;             // Host data bus width
   localparam int SRX_BANKS = 4;               // Banks in the array
   localparam int SRX_BANK_BYTES = 4096;       // Bytes per bank
   localparam int SRX_MAP_BYTES = 8192;        // Placement boundary in bytes
   localparam int SRX_CODE_W = 4;              // Map switch positions
   localparam int SRX_PAGE_LSB = 12;           // Lowest address bit above one bank
   localparam int SRX_WORD_W = 11;             // Word address within one bank (2K x 16)
   localparam int SRX_BANK_W = 2;              // Bank index width
   localparam int SRX_BANK_SPAN_W = 3;         // Wide enough to hold a bank count
   // ****************************************************************
   // Map decode fields
   // ****************************************************************
   localparam int SRX_BASE_MSB = 2;            // Code bits that pick the 8K base
   localparam int SRX_SIZE_BIT = 3;            // Code bit that picks the window size
   localparam logic [SRX_BANK_SPAN_W-1:0] SRX_FULL_BANKS = 3'h4; // Whole array mapped
   localparam logic [SRX_BANK_SPAN_W-1:0] SRX_HALF_BANKS = 3'h2; // Lower half mapped
   localparam logic [SRX_BANKS-1:0] SRX_NO_BANK_N = 4'hf;         // All bank selects idle
   localparam logic [SRX_DATA_W-1:0] SRX_DATA_RST = 16'h0000;     // Read data at reset
   localparam logic [SRX_WORD_W-1:0] SRX_WORD_RST = 11'h000;      // Word address at reset

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic {SRX_SPEED_FAST, SRX_SPEED_SLOW} srx_speed_e;

   typedef enum {SRX_IDLE, SRX_WAIT, SRX_ACCESS} srx_state_e;

   // Backplane memory cycle signals, all synchronous to the CPU clock
   typedef struct packed {
      logic [SRX_ADDR_W-1:0] addr;             // Byte address, bit 15 most significant
      logic memEn_n;                           // Memory cycle in progress, low
      logic dbIn;                              // High when the host reads
      logic we_n;                              // Write strobe, low
      logic [SRX_DATA_W-1:0] wrData;           // Data from the host
   } srx_host_s;

   // Strobes toward the RAM array
   typedef struct packed {
      logic [SRX_BANKS-1:0] bankSel_n;         // One bank select per bank, low
      logic [SRX_WORD_W-1:0] wordAddr;         // Word within the bank
      logic we_n;                              // Array write, low
      logic oe_n;                              // Array output enable, low
   } srx_ram_s;
endpackage

// *** srx_ram_ctrl.sv ***
// Static RAM expansion board controller: map decode, bank select and wait state
`timescale 1ns/100ps
module srx_ram_ctrl
   import srx_pkg::*;
#(
   parameter int NUM_BANKS = SRX_BANKS         // Banks fitted, at most four
)
(
   input wire logic sys_clk,                   // CPU clock, 25 MHz
   input wire logic resetn,                    // Asynchronous reset, low
   input wire srx_host_s hostBus,              // Backplane memory cycle signals
   input wire logic ramSpeedJumper,            // Speed jumper pin, high is slow
   input wire logic [SRX_CODE_W-1:0] mapSelectSwitch, // Map switch pins, off pulls high
   input wire logic [SRX_DATA_W-1:0] ramRdData, // Data from the array
   output logic [SRX_DATA_W-1:0] ramWrData,    // Data to the array
   output srx_ram_s ramCtl,                    // Array strobes and address
   output logic [SRX_DATA_W-1:0] busDataOut,   // Read data toward the backplane
   output logic busDataOe,                     // High while driving the data bus
   output logic busReady,                      // Ready level toward the host
   output logic busReadyOe                     // High while driving ready
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // The array holds at most 16K bytes
   if (NUM_BANKS < 1 || NUM_BANKS > SRX_BANKS)
   begin : gBankCheck
      $error("NUM_BANKS must lie between one and four");
   end

   // Page decode takes one bank per address page and a placement step of two pages
   if (SRX_BANK_BYTES != (1 << SRX_PAGE_LSB) || SRX_MAP_BYTES != 2 * SRX_BANK_BYTES)
   begin : gPageCheck
      $error("Bank size or placement step does not fit the page decode");
   end

   // Word address must fill one page exactly, and the bank index must count every bank
   if (SRX_WORD_W != SRX_PAGE_LSB - 1 || (1 << SRX_BANK_W) != SRX_BANKS)
   begin : gWidthCheck
      $error("Word or bank index width does not match the bank geometry");
   end

   // ****************************************************************
   // Map decode
   // ****************************************************************
   // Base in 4K pages from the switch code; base on 8K steps, size from the top bit
   function automatic logic [SRX_BANK_SPAN_W:0] windowOffset(
      input logic [SRX_CODE_W-1:0] code,
      input logic [SRX_ADDR_W-1:0] addr);
      logic [SRX_CODE_W-1:0] basePage;
      logic [SRX_CODE_W:0] diff;
      logic [SRX_BANK_SPAN_W-1:0] span;
      logic hit;
      basePage = {code[SRX_BASE_MSB:0], 1'b0};
      diff = {1'b0, addr[SRX_ADDR_W-1:SRX_PAGE_LSB]} - {1'b0, basePage};
      span = code[SRX_SIZE_BIT] ? SRX_HALF_BANKS : SRX_FULL_BANKS;
      if (span > NUM_BANKS[SRX_BANK_SPAN_W-1:0])
      begin
         span = NUM_BANKS[SRX_BANK_SPAN_W-1:0];
      end
      // Negative difference means below the base: no wrap past the top of memory
      hit = !diff[SRX_CODE_W] && (diff < {2'b00, span});
      windowOffset = {hit, diff[SRX_BANK_SPAN_W-1:0]};
   endfunction

   // ****************************************************************
   // Strap synchronisers
   // ****************************************************************
   // Jumper and switch are asynchronous pins; two flops before any use
   logic jumperMeta_r, jumper_r, jumperMeta_nxt, jumper_nxt;
   logic [SRX_CODE_W-1:0] switchMeta_r, switch_r, switchMeta_nxt, switch_nxt;

   // Next values of the synchroniser chains
   always_comb
   begin
      jumperMeta_nxt = ramSpeedJumper;
      jumper_nxt = jumperMeta_r;
      switchMeta_nxt = mapSelectSwitch;
      switch_nxt = switchMeta_r;
   end

   // Register the synchroniser chains
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         jumperMeta_r <= 1'b1;                 // Slow is the safe default
         jumper_r <= 1'b1;
         switchMeta_r <= '1;
         switch_r <= '1;
      end
      else
      begin
         jumperMeta_r <= jumperMeta_nxt;
         jumper_r <= jumper_nxt;
         switchMeta_r <= switchMeta_nxt;
         switch_r <= switch_nxt;
      end
   end

   // Off pulls the pin high, so the pin level is already the binary digit
   logic [SRX_CODE_W-1:0] mapCode;
   srx_speed_e speed;
   assign mapCode = switch_r;
   assign speed = jumper_r ? SRX_SPEED_SLOW : SRX_SPEED_FAST;

   // ****************************************************************
   // Cycle sequencer
   // ****************************************************************
   logic [SRX_BANK_SPAN_W:0] decode;
   logic hit;
   logic [SRX_BANK_W-1:0] bankIdx;
   assign decode = windowOffset(mapCode, hostBus.addr);
   assign hit = decode[SRX_BANK_SPAN_W];
   assign bankIdx = decode[SRX_BANK_W-1:0];

   srx_state_e state_r, state_nxt;
   logic [SRX_BANKS-1:0] bankSel_n_r, bankSel_n_nxt;
   logic [SRX_WORD_W-1:0] wordAddr_r, wordAddr_nxt;
   logic read_r, read_nxt;
   logic [SRX_DATA_W-1:0] rdData_r, rdData_nxt;
   logic [SRX_DATA_W-1:0] wrData_r, wrData_nxt;

   // Next state: the cycle is taken on memEn_n low with the address inside the mapped window
   always_comb
   begin
      state_nxt = state_r;
      bankSel_n_nxt = bankSel_n_r;
      wordAddr_nxt = wordAddr_r;
      read_nxt = read_r;
      rdData_nxt = rdData_r;
      wrData_nxt = hostBus.wrData;             // Host holds write data for the whole cycle
      case (state_r)
         SRX_IDLE:
         begin
            if (!hostBus.memEn_n && hit)
            begin
               for (int b = 0; b < SRX_BANKS; b++)
               begin
                  bankSel_n_nxt[b] = (bankIdx != b[SRX_BANK_W-1:0]);
               end
               // Byte address to 16-bit word: bit 0 selects a byte and is not used
               wordAddr_nxt = hostBus.addr[SRX_PAGE_LSB-1:1];
               read_nxt = hostBus.dbIn;
               // Slow parts get one extra clock before ready is released
               state_nxt = (speed == SRX_SPEED_SLOW) ? SRX_WAIT : SRX_ACCESS;
            end
         end
         SRX_WAIT:
         begin
            state_nxt = SRX_ACCESS;            // exactly one wait clock
         end
         SRX_ACCESS:
         begin
            rdData_nxt = ramRdData;
            if (hostBus.memEn_n)
            begin
               state_nxt = SRX_IDLE;
               bankSel_n_nxt = SRX_NO_BANK_N;
               read_nxt = 1'b0;
            end
         end
         default:
         begin
            state_nxt = SRX_IDLE;
            bankSel_n_nxt = SRX_NO_BANK_N;
            read_nxt = 1'b0;
         end
      endcase
   end

   // Register the sequencer
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= SRX_IDLE;
         bankSel_n_r <= SRX_NO_BANK_N;
         wordAddr_r <= SRX_WORD_RST;
         read_r <= 1'b0;
         rdData_r <= SRX_DATA_RST;
         wrData_r <= SRX_DATA_RST;
      end
      else
      begin
         state_r <= state_nxt;
         bankSel_n_r <= bankSel_n_nxt;
         wordAddr_r <= wordAddr_nxt;
         read_r <= read_nxt;
         rdData_r <= rdData_nxt;
         wrData_r <= wrData_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Ready and data are only driven while this board owns the cycle
   assign busReadyOe = (state_r != SRX_IDLE);
   assign busReady = (state_r != SRX_WAIT);
   assign busDataOe = (state_r == SRX_ACCESS) && read_r;
   assign busDataOut = rdData_r;

   // Write data is registered; it trails the host by a clock and, with fast parts, loads on the same edge that opens the write strobe
   assign ramWrData = wrData_r;
   assign ramCtl = '{
      bankSel_n: bankSel_n_r,
      wordAddr: wordAddr_r,
      we_n: !((state_r == SRX_ACCESS) && !read_r && !hostBus.we_n),
      oe_n: !((state_r != SRX_IDLE) && read_r)
   };
endmodule

// *** srx_ram_ctrl_props.sv ***
// Checker of the RAM controller ports
`timescale 1ns/100ps
module srx_ram_ctrl_props
   import srx_pkg::*;
#(parameter int NUM_BANKS = SRX_BANKS)
(
   input wire logic sys_clk, // Clock
   input wire logic resetn, // Reset, low
   input wire srx_host_s hostBus, // Host cycle
   input wire logic ramSpeedJumper, // High slow
   input wire logic [SRX_CODE_W-1:0] mapSelectSwitch, // Map code
   input wire logic [SRX_DATA_W-1:0] ramRdData, // From array
   input wire logic [SRX_DATA_W-1:0] ramWrData, // To array
   input wire srx_ram_s ramCtl, // Strobes
   input wire logic [SRX_DATA_W-1:0] busDataOut, // Read data
   input wire logic busDataOe, // Data enable
   input wire logic busReady, // Ready
   input wire logic busReadyOe // Ready enable
);
   logic [4:0] off;
   logic hit;
   // Window decode from the raw switch, valid as straps settle before any cycle
   assign off = {1'b0, hostBus.addr[15:12]} - {1'b0, mapSelectSwitch[2:0], 1'b0};
   assign hit = off < (mapSelectSwitch[3] ? 2 : 4) && off < NUM_BANKS;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   chk_owner_bank: assert property (busReadyOe == (ramCtl.bankSel_n != SRX_NO_BANK_N)) else $error("owner");
   chk_take_hit: assert property (!busReadyOe && !hostBus.memEn_n && hit |=> busReadyOe)
      else $error("take");
   chk_refuse_miss: assert property (!busReadyOe && !hit |=> !busReadyOe) else $error("miss");
   chk_bank_pick: assert property ($rose(busReadyOe) |-> ramCtl.bankSel_n == ~(4'h1 << off[1:0]))
      else $error("bank");
   chk_wait_set: assert property ($rose(busReadyOe) |-> busReady != ramSpeedJumper) else $error("wait");
   chk_wait_once: assert property (busReadyOe && !busReady |=> busReadyOe && busReady)
      else $error("wait once");
   chk_word_path: assert property (busReadyOe |-> ramCtl.wordAddr == hostBus.addr[11:1]
      && ramWrData == hostBus.wrData) else $error("word");
   chk_strobe_dir: assert property (!ramCtl.we_n || busDataOe |-> busReady && hostBus.dbIn == busDataOe)
      else $error("strobe");
   chk_read_data: assert property (busDataOe |=> busDataOut == $past(ramRdData)) else $error("read data");
   chk_cycle_end: assert property (busReadyOe && hostBus.memEn_n |=> !busReadyOe) else $error("release");
   cov_slow: cover property ($rose(busReadyOe) && !busReady);
   cov_write: cover property (!ramCtl.we_n);
   cov_miss: cover property (!hostBus.memEn_n && !hit);
endmodule
bind srx_ram_ctrl srx_ram_ctrl_props #(.NUM_BANKS(NUM_BANKS)) srx_ram_ctrl_props_inst (.sys_clk(sys_clk),
   .resetn(resetn), .hostBus(hostBus), .ramSpeedJumper(ramSpeedJumper), .mapSelectSwitch(mapSelectSwitch),
   .ramRdData(ramRdData), .ramWrData(ramWrData), .ramCtl(ramCtl), .busDataOut(busDataOut),
   .busDataOe(busDataOe), .busReady(busReady), .busReadyOe(busReadyOe));

// *** srx_ram_model.sv ***
// Behavioural model of the banked RAM array
`timescale 1ns/100ps
module srx_ram_model
   import srx_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire srx_ram_s ramCtl, // Strobes
   input wire logic [SRX_DATA_W-1:0] ramWrData, // Data in
   output logic [SRX_DATA_W-1:0] ramRdData // Data out
);
   logic [SRX_DATA_W-1:0] mem [SRX_BANKS][2**SRX_WORD_W];
   logic [SRX_DATA_W-1:0] lastRd = 16'h0000;
   logic [SRX_BANK_W-1:0] bank;
   logic sel;
   // Bank from the selects; none selected leaves the array silent
   always_comb
   begin
      bank = '0;
      for (int i = 0; i < SRX_BANKS; i++)
         if (!ramCtl.bankSel_n[i])
            bank = i[SRX_BANK_W-1:0];
   end
   assign sel = ramCtl.bankSel_n != SRX_NO_BANK_N;
   // Released bus toggles every cycle so a stale value never passes
   assign ramRdData = (!ramCtl.oe_n && sel) ? mem[bank][ramCtl.wordAddr] : ~lastRd;
   // Writes land on the edge
   always @(posedge sys_clk)
   begin
      if (!ramCtl.we_n && sel)
         mem[bank][ramCtl.wordAddr] <= ramWrData;
      lastRd <= ramRdData;
   end
endmodule

// *** static_ram_expansion_board_controller_bench.sv ***
// Bench for the RAM controller: map sweep, wait state and data path
`timescale 1ns/100ps
module static_ram_expansion_board_controller_bench
   import srx_pkg::*;
;
   logic sys_clk = 1'b0, resetn = 1'b0, ramSpeedJumper = 1'b0, busDataOe, busReady, busReadyOe;
   logic [3:0] mapSelectSwitch = 4'h0;
   logic [15:0] ramRdData, ramWrData, busDataOut;
   srx_host_s hostBus = '{16'h0, 1'b1, 1'b0, 1'b1, 16'h0};
   srx_ram_s ramCtl;
   int errCount = 0, comparisons = 0;
   // Clock of 40 ns
   always #20 sys_clk = ~sys_clk;
   srx_ram_ctrl srx_ram_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn), .hostBus(hostBus),
      .ramSpeedJumper(ramSpeedJumper), .mapSelectSwitch(mapSelectSwitch), .ramRdData(ramRdData),
      .ramWrData(ramWrData), .ramCtl(ramCtl), .busDataOut(busDataOut), .busDataOe(busDataOe),
      .busReady(busReady), .busReadyOe(busReadyOe));
   srx_ram_model srx_ram_model_inst (.sys_clk(sys_clk), .ramCtl(ramCtl), .ramWrData(ramWrData),
      .ramRdData(ramRdData));
   task automatic printVerdict();
      $display("comparisons %0d, mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Straps pass two flops, so give them three cycles before a cycle
   task automatic set_straps(input logic [3:0] code, input logic slow);
      @(negedge sys_clk);
      mapSelectSwitch = code;
      ramSpeedJumper = slow;
      repeat (3) @(negedge sys_clk);
   endtask
   // One host word cycle; the request holds one clock past ready, or four clocks if ready never comes
   task automatic bus_cycle(input logic [15:0] a, input logic rd, input logic [15:0] d, input logic hit);
      int n;
      @(negedge sys_clk);
      hostBus = '{a, 1'b0, rd, rd, d};
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (!(busReadyOe === 1'b1 && busReady === 1'b1) && n < 4);
      if (!hit)
         check({15'h0, busReadyOe}, 16'h0000);
      else if (n >= 4)
      begin
         errCount++;
         printVerdict();
      end
      else
      begin
         check(16'(n), ramSpeedJumper ? 16'h0002 : 16'h0001);
         check({14'h0, busDataOe, ramCtl.we_n}, {14'h0, rd, rd});
         @(negedge sys_clk);
         if (rd)
            check(busDataOut, d);
      end
      hostBus.memEn_n = 1'b1;
      @(negedge sys_clk);
      check({12'h0, ramCtl.bankSel_n}, 16'h000f);
   endtask
   task automatic scen_reset();
      #30;
      check({ramCtl.bankSel_n, busDataOe, busReady, busReadyOe, ramCtl.oe_n, 8'h00}, 16'hf500);
      check(busDataOut, SRX_DATA_RST);
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
   endtask
   // Every code: both window ends hit, the pages either side miss
   task automatic scen_map_sweep();
      logic [3:0] base, last;
      for (int c = 0; c < 16; c++)
      begin
         set_straps(c[3:0], 1'b0);
         base = {c[2:0], 1'b0};
         last = base + (c[3] ? 4'h1 : 4'h3);
         if (last < base)
            last = 4'hf;
         bus_cycle({last, 12'hffe}, 1'b0, {c[3:0], 12'ha5c}, 1'b1);
         bus_cycle({base, 12'h002}, 1'b0, {c[3:0], 12'h3c1}, 1'b1);
         bus_cycle({last, 12'hfff}, 1'b1, {c[3:0], 12'ha5c}, 1'b1);
         bus_cycle({base, 12'h002}, 1'b1, {c[3:0], 12'h3c1}, 1'b1);
         bus_cycle({last + 4'h1, 12'h000}, 1'b1, 16'h0000, 1'b0);
         bus_cycle({base - 4'h1, 12'hffe}, 1'b1, 16'h0000, 1'b0);
      end
   endtask
   // Slow parts: every cycle gets one wait, back to back
   task automatic scen_slow();
      set_straps(4'h6, 1'b1);
      bus_cycle(16'hc000, 1'b0, 16'h1234, 1'b1);
      bus_cycle(16'hd802, 1'b0, 16'h5678, 1'b1);
      bus_cycle(16'hc000, 1'b1, 16'h1234, 1'b1);
      bus_cycle(16'hd802, 1'b1, 16'h5678, 1'b1);
   endtask
   // Reset in the middle of a slow read drops the bus at once; straps resettle before the next cycle
   task automatic scen_mid_reset();
      @(negedge sys_clk);
      hostBus = '{16'hc000, 1'b0, 1'b1, 1'b1, 16'h0000};
      @(negedge sys_clk);
      check({15'h0, busReadyOe}, 16'h0001);
      resetn = 1'b0;
      hostBus.memEn_n = 1'b1;
      #1;
      check({12'h0, ramCtl.bankSel_n}, 16'h000f);
      check({14'h0, busReadyOe, busDataOe}, 16'h0000);
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (2) @(negedge sys_clk);
      bus_cycle(16'hd802, 1'b1, 16'h5678, 1'b1);
   endtask
   // Main sequence
   initial
   begin
      scen_reset();
      scen_map_sweep();
      scen_slow();
      scen_mid_reset();
      printVerdict();
   end
endmodule
